// [sleep_wake_pkg.sv]
// Shared constants for the cyclic sleep and wake controller.
// Assumes a 20 MHz mclk and a 100 ms timebase derived from it.
package sleep_wake_pkg;

  // Clock and time units
  localparam int CLK_HZ        = 20_000_000;
  localparam int TICK_MS       = 100;
  localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int DETECT_MS     = 35;
  localparam int DETECT_CYCLES = CLK_HZ / 1000 * DETECT_MS;
  localparam int LISTEN_MS     = 50;
  localparam int LISTEN_CYCLES = CLK_HZ / 1000 * LISTEN_MS;

  // Register indices on the plain register port
  localparam logic [2:0] REG_SLEEP_SELECT  = 3'h0;
  localparam logic [2:0] REG_INACTIVITY    = 3'h1;
  localparam logic [2:0] REG_HOLDOFF       = 3'h2;
  localparam logic [2:0] REG_DURATION      = 3'h3;
  localparam logic [2:0] REG_PIN_WAKE      = 3'h4;
  localparam logic [2:0] REG_FORCE_INIT    = 3'h5;
  localparam logic [2:0] REG_STATUS        = 3'h6;

  // Reset values and limits
  localparam logic [3:0]  SEL_RESET     = 4'h0;
  localparam logic [15:0] TMO_RESET     = 16'h0064;
  localparam logic [15:0] TMO_MIN       = 16'h0010;
  localparam logic [15:0] HOLD_RESET    = 16'hFFFF;
  localparam logic [15:0] HOLD_DISABLED = 16'hFFFF;
  localparam logic [7:0]  DUR_RESET     = 8'h01;

  // Sleep select encodings
  localparam logic [3:0] SEL_DISABLED  = 4'h0;
  localparam logic [3:0] SEL_PIN       = 4'h1;
  localparam logic [3:0] SEL_INVALID   = 4'h2;
  localparam logic [3:0] SEL_CYC_FIRST = 4'h3;
  localparam logic [3:0] SEL_CYC_LAST  = 4'h8;

  // Wake periods in 100 ms ticks: 0.5, 1, 2, 4, 8, 16 s
  localparam logic [7:0] WAKE_0P5 = 8'h05;
  localparam logic [7:0] WAKE_1   = 8'h0A;
  localparam logic [7:0] WAKE_2   = 8'h14;
  localparam logic [7:0] WAKE_4   = 8'h28;
  localparam logic [7:0] WAKE_8   = 8'h50;
  localparam logic [7:0] WAKE_16  = 8'hA0;

  typedef enum logic [1:0] {
    ST_ACTIVE  = 2'b00,
    ST_SLEEP   = 2'b01,
    ST_LISTEN  = 2'b10,
    ST_RECEIVE = 2'b11
  } state_e;

endpackage : sleep_wake_pkg

// [pin_sync.sv]
// Three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to mclk.
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_s;

  sync_s r;
  sync_s next_r;

  // First stage feeds only the second
  always_comb begin
    next_r     = r;
    next_r.s1  = pin;
    next_r.s2  = r.s1;
    next_r.s3  = r.s2;
    if (r.s2 == r.s3) begin
      next_r.lvl = r.s3;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign level = r.lvl;
endmodule : pin_sync
`default_nettype wire

// [cyclic_sleep_wake_controller.sv]
// Cyclic sleep and wake sequencer with initializer timing and registers.
// Assumes activity and tx strobes on mclk; sleep pin and detect are async.
`timescale 1ns/1ns
`default_nettype none
module cyclic_sleep_wake_controller #(
  parameter int TICK_CYCLES   = sleep_wake_pkg::TICK_CYCLES,
  parameter int DETECT_CYCLES = sleep_wake_pkg::DETECT_CYCLES,
  parameter int LISTEN_CYCLES = sleep_wake_pkg::LISTEN_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [2:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        serial_activity,
  input  wire logic        radio_activity,
  input  wire logic        tx_pending,
  input  wire logic        tx_start,
  input  wire logic        sleep_pin,
  input  wire logic        initializer_detect,
  output logic             asleep,
  output logic             listening,
  output logic             receiving,
  output logic             initializer_on
);
  typedef struct packed {
    sleep_wake_pkg::state_e st;
    logic [3:0]  sleep_select;
    logic [15:0] inactivity_timeout;
    logic [15:0] initializer_holdoff;
    logic [7:0]  initializer_duration;
    logic        pin_wake_enable;
    logic        force_initializer;
    logic [21:0] tick_cnt;
    logic [15:0] idle_ticks;
    logic [15:0] hold_ticks;
    logic [7:0]  sleep_ticks;
    logic [21:0] window_cnt;
    logic [21:0] detect_cnt;
    logic [7:0]  init_ticks;
    logic        init_on;
    logic        asleep;
    logic        listening;
    logic        receiving;
    logic [15:0] rdata;
  } ctl_s;

  ctl_s r;
  ctl_s next_r;

  logic pin_level;
  logic detect_level;

  pin_sync u_pin_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pin   (sleep_pin),
    .level (pin_level)
  );

  pin_sync u_detect_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pin   (initializer_detect),
    .level (detect_level)
  );

  logic       tick;
  logic       cyclic;
  logic       pin_hold;
  logic       activity;
  logic       init_due;
  logic [7:0] wake_period;

  always_comb begin
    tick     = (r.tick_cnt == 22'(TICK_CYCLES - 1));
    cyclic   = (r.sleep_select >= sleep_wake_pkg::SEL_CYC_FIRST) &&
               (r.sleep_select <= sleep_wake_pkg::SEL_CYC_LAST);
    pin_hold = cyclic && r.pin_wake_enable && !pin_level;
    activity = serial_activity || radio_activity || tx_start;
    init_due = r.force_initializer ||
               ((r.initializer_holdoff != sleep_wake_pkg::HOLD_DISABLED) &&
                (r.hold_ticks >= r.initializer_holdoff));
    case (r.sleep_select)
      4'h3:    wake_period = sleep_wake_pkg::WAKE_0P5;
      4'h4:    wake_period = sleep_wake_pkg::WAKE_1;
      4'h5:    wake_period = sleep_wake_pkg::WAKE_2;
      4'h6:    wake_period = sleep_wake_pkg::WAKE_4;
      4'h7:    wake_period = sleep_wake_pkg::WAKE_8;
      default: wake_period = sleep_wake_pkg::WAKE_16;
    endcase
  end

  always_comb begin
    next_r       = r;
    next_r.rdata = '0;
    next_r.tick_cnt = tick ? '0 : r.tick_cnt + 22'h000001;

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        sleep_wake_pkg::REG_SLEEP_SELECT: begin
          // Invalid codes leave the old selection in place
          if (reg_wdata[3:0] != sleep_wake_pkg::SEL_INVALID &&
              reg_wdata[15:4] == '0 &&
              reg_wdata[3:0] <= sleep_wake_pkg::SEL_CYC_LAST) begin
            next_r.sleep_select = reg_wdata[3:0];
          end
        end
        sleep_wake_pkg::REG_INACTIVITY: begin
          next_r.inactivity_timeout = (reg_wdata < sleep_wake_pkg::TMO_MIN) ?
            sleep_wake_pkg::TMO_MIN : reg_wdata;
        end
        sleep_wake_pkg::REG_HOLDOFF: begin
          next_r.initializer_holdoff = reg_wdata;
        end
        sleep_wake_pkg::REG_DURATION: begin
          next_r.initializer_duration = reg_wdata[7:0];
        end
        sleep_wake_pkg::REG_PIN_WAKE: begin
          next_r.pin_wake_enable = reg_wdata[0];
        end
        default: begin
        end
      endcase
    end

    // Register reads, data valid the next cycle
    if (reg_rd) begin
      case (reg_addr)
        sleep_wake_pkg::REG_SLEEP_SELECT:
          next_r.rdata = {12'h000, r.sleep_select};
        sleep_wake_pkg::REG_INACTIVITY: next_r.rdata = r.inactivity_timeout;
        sleep_wake_pkg::REG_HOLDOFF:    next_r.rdata = r.initializer_holdoff;
        sleep_wake_pkg::REG_DURATION:
          next_r.rdata = {8'h00, r.initializer_duration};
        sleep_wake_pkg::REG_PIN_WAKE:
          next_r.rdata = {15'h0000, r.pin_wake_enable};
        sleep_wake_pkg::REG_STATUS:
          next_r.rdata = {10'h000, pin_level, init_due, r.init_on,
                          r.force_initializer, r.st};
        default: next_r.rdata = '0;
      endcase
    end

    // Idle and holdoff counters, saturating
    if (activity || pin_hold) begin
      next_r.idle_ticks = '0;
    end else if (tick && r.idle_ticks != 16'hFFFF) begin
      next_r.idle_ticks = r.idle_ticks + 16'h0001;
    end
    if (activity) begin
      next_r.hold_ticks = '0;
    end else if (tick && r.hold_ticks != 16'hFFFF) begin
      next_r.hold_ticks = r.hold_ticks + 16'h0001;
    end

    // Initializer transmit timing; uses the state before the restart
    if (tx_start && !r.init_on && init_due &&
        r.initializer_duration != 8'h00) begin
      next_r.init_on    = 1'b1;
      next_r.init_ticks = '0;
    end else if (r.init_on && tick) begin
      if (r.init_ticks + 8'h01 >= r.initializer_duration) begin
        next_r.init_on = 1'b0;
      end
      next_r.init_ticks = r.init_ticks + 8'h01;
    end

    // A force write in the same cycle as its use survives
    if (reg_wr && reg_addr == sleep_wake_pkg::REG_FORCE_INIT) begin
      next_r.force_initializer = 1'b1;
    end else if (tx_start) begin
      next_r.force_initializer = 1'b0;
    end

    // Sleep sequencing
    case (r.st)
      sleep_wake_pkg::ST_ACTIVE: begin
        if (cyclic && !pin_hold && !tx_pending && !activity &&
            r.idle_ticks >= r.inactivity_timeout) begin
          next_r.st          = sleep_wake_pkg::ST_SLEEP;
          next_r.sleep_ticks = '0;
        end
      end
      sleep_wake_pkg::ST_SLEEP: begin
        if (!cyclic || pin_hold || tx_pending) begin
          next_r.st = sleep_wake_pkg::ST_ACTIVE;
        end else if (tick) begin
          if (r.sleep_ticks + 8'h01 >= wake_period) begin
            next_r.st         = sleep_wake_pkg::ST_LISTEN;
            next_r.window_cnt = '0;
            next_r.detect_cnt = '0;
          end
          next_r.sleep_ticks = r.sleep_ticks + 8'h01;
        end
      end
      sleep_wake_pkg::ST_LISTEN: begin
        next_r.window_cnt = r.window_cnt + 22'h000001;
        next_r.detect_cnt = detect_level ? r.detect_cnt + 22'h000001 : '0;
        if (!cyclic || pin_hold || tx_pending) begin
          next_r.st = sleep_wake_pkg::ST_ACTIVE;
        end else if (detect_level &&
                     r.detect_cnt >= 22'(DETECT_CYCLES - 1)) begin
          next_r.st = sleep_wake_pkg::ST_RECEIVE;
        end else if (r.window_cnt >= 22'(LISTEN_CYCLES - 1) &&
                     r.detect_cnt == '0) begin
          // Window ends only outside a run of initializer
          next_r.st          = sleep_wake_pkg::ST_SLEEP;
          next_r.sleep_ticks = '0;
        end
      end
      sleep_wake_pkg::ST_RECEIVE: begin
        // Data follows once the initializer stops
        if (!detect_level || !cyclic || pin_hold) begin
          next_r.st         = sleep_wake_pkg::ST_ACTIVE;
          next_r.idle_ticks = '0;
        end
      end
      default: next_r.st = sleep_wake_pkg::ST_ACTIVE;
    endcase

    next_r.asleep    = (next_r.st == sleep_wake_pkg::ST_SLEEP) ||
                       (r.sleep_select == sleep_wake_pkg::SEL_PIN &&
                        pin_level);
    next_r.listening = (next_r.st == sleep_wake_pkg::ST_LISTEN);
    next_r.receiving = (next_r.st == sleep_wake_pkg::ST_RECEIVE);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r                      <= '0;
      r.st                   <= sleep_wake_pkg::ST_ACTIVE;
      r.sleep_select         <= sleep_wake_pkg::SEL_RESET;
      r.inactivity_timeout   <= sleep_wake_pkg::TMO_RESET;
      r.initializer_holdoff  <= sleep_wake_pkg::HOLD_RESET;
      r.initializer_duration <= sleep_wake_pkg::DUR_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign reg_rdata      = r.rdata;
  assign asleep         = r.asleep;
  assign listening      = r.listening;
  assign receiving      = r.receiving;
  assign initializer_on = r.init_on;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_SLEEP_AFTER_IDLE: assert property (
    r.st == sleep_wake_pkg::ST_ACTIVE ##1 r.st == sleep_wake_pkg::ST_SLEEP
    |-> $past(r.idle_ticks) >= $past(r.inactivity_timeout)
  ) else $error("Sleep entered before inactivity timeout");

  // Non-cyclic selection forces the active state on the next edge
  AST_SLEEP_ONLY_CYCLIC: assert property (
    !cyclic |=> r.st == sleep_wake_pkg::ST_ACTIVE
  ) else $error("Sleep state held outside cyclic selection");

  AST_INVALID_SELECT: assert property (
    reg_wr && reg_addr == sleep_wake_pkg::REG_SLEEP_SELECT &&
    reg_wdata == 16'h0002 |=> $stable(r.sleep_select)
  ) else $error("Invalid sleep select was accepted");

  AST_DISABLED_AWAKE: assert property (
    r.sleep_select == sleep_wake_pkg::SEL_DISABLED [*2] |-> !asleep
  ) else $error("Asleep while sleep is disabled");

  AST_LISTEN_WINDOW: assert property (
    $rose(r.st == sleep_wake_pkg::ST_LISTEN) |->
    $past(r.sleep_ticks) + 8'h01 >= $past(wake_period)
  ) else $error("Woke before wake period elapsed");

  AST_DETECT_35MS: assert property (
    $rose(r.st == sleep_wake_pkg::ST_RECEIVE) |->
    $past(r.detect_cnt) >= 22'(DETECT_CYCLES - 1)
  ) else $error("Stayed awake without enough initializer");

  AST_HOLDOFF_OFF: assert property (
    tx_start && !r.force_initializer && !r.init_on &&
    r.initializer_holdoff == sleep_wake_pkg::HOLD_DISABLED |=> !r.init_on
  ) else $error("Initializer sent while holdoff disabled");

  AST_DURATION_BOUND: assert property (
    r.init_on |-> r.init_ticks < r.initializer_duration
  ) else $error("Initializer ran past its duration");

  AST_FORCE_NEXT: assert property (
    tx_start && r.force_initializer && !r.init_on &&
    r.initializer_duration != 8'h00 |=> r.init_on ##1 !r.force_initializer
    || reg_wr
  ) else $error("Forced initializer not sent");

  AST_PIN_KEEPS_AWAKE: assert property (
    pin_hold && r.st != sleep_wake_pkg::ST_ACTIVE |=>
    r.st == sleep_wake_pkg::ST_ACTIVE ##1 r.st == sleep_wake_pkg::ST_ACTIVE
    || !pin_hold
  ) else $error("Low sleep pin did not hold device awake");

  AST_ACTIVITY_RESTART: assert property (
    activity |=> r.idle_ticks == '0 && r.hold_ticks == '0
  ) else $error("Activity did not restart counters");

endmodule : cyclic_sleep_wake_controller
`default_nettype wire

// [peer_model.sv]
// Remote radio peer plus host drive of the sleep pin.
// Assumes the bench commands bursts; pins move off the mclk edge.
`timescale 1ns/1ns
`default_nettype none
module peer_model (
  input  wire logic        mclk,
  input  wire logic        burst_go,
  input  wire logic [15:0] burst_len,
  input  wire logic        pin_level,
  output wire logic        sleep_pin,
  output wire logic        initializer_detect
);
  logic [15:0] rem;

  initial rem = 16'h0000;

  // Initializer lasts the commanded length, no more
  always @(posedge mclk) begin
    if (burst_go) begin
      rem <= burst_len;
    end else if (rem != 16'h0000) begin
      rem <= rem - 16'h0001;
    end
  end

  // Both lines are async to mclk, so skew them off the edge
  assign #7 initializer_detect = (rem != 16'h0000);
  assign #3 sleep_pin = pin_level;
endmodule : peer_model
`default_nettype wire

// [tb.sv]
// Self-checking bench for the cyclic sleep and wake controller.
// Assumes short tick and detect parameters; peer_model drives async pins.
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int T  = 10;
  localparam int DC = 4;
  localparam int LC = 8;
  logic        mclk;
  logic        rst_n;
  logic [2:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        serial_activity;
  logic        radio_activity;
  logic        tx_pending;
  logic        tx_start;
  wire logic   sleep_pin;
  wire logic   initializer_detect;
  logic        asleep;
  logic        listening;
  logic        receiving;
  logic        initializer_on;
  logic        burst_go;
  logic [15:0] burst_len;
  logic        pin_level;
  logic [3:0]  outs;
  logic [15:0] d;
  int          fail_count;
  int          n_checks;
  int          dur;
  int          w;

  assign outs = {initializer_on, receiving, listening, asleep};

  cyclic_sleep_wake_controller #(
    .TICK_CYCLES(T), .DETECT_CYCLES(DC), .LISTEN_CYCLES(LC)
  ) dut (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .serial_activity(serial_activity),
    .radio_activity(radio_activity), .tx_pending(tx_pending),
    .tx_start(tx_start), .sleep_pin(sleep_pin),
    .initializer_detect(initializer_detect), .asleep(asleep),
    .listening(listening), .receiving(receiving),
    .initializer_on(initializer_on)
  );

  peer_model peer (
    .mclk(mclk), .burst_go(burst_go), .burst_len(burst_len),
    .pin_level(pin_level), .sleep_pin(sleep_pin),
    .initializer_detect(initializer_detect)
  );

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic test_done;
    if (fail_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Bounded wait; too early or too late both count
  task automatic wt(input string nm, input int i, input logic v,
                    input int lo, input int hi);
    int k;
    k = 0;
    while (outs[i] !== v && k <= hi) begin
      @(posedge mclk);
      #1;
      k++;
    end
    n_checks++;
    if (k < lo || k > hi) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0d to %0d seen %0d", nm, lo, hi, k);
      if (k > hi) test_done();
    end
  endtask : wt

  task automatic hold(input string nm, input int i, input logic v,
                      input int cyc);
    int bad;
    bad = 0;
    repeat (cyc) begin
      @(posedge mclk);
      #1;
      if (outs[i] !== v) bad++;
    end
    chk(nm, 16'h0000, bad[15:0]);
  endtask : hold

  // Wake period in ticks for cyclic selections 3..8: 0.5 s doubling
  function automatic int wake_ticks(input int sel);
    return 5 << (sel - 3);
  endfunction : wake_ticks

  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rc(input logic [2:0] a, input logic [15:0] e);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    chk($sformatf("register %0d", a), e, d);
  endtask : rc

  // 0 serial, 1 radio, 2 transmit start
  task automatic strobe(input int k);
    @(posedge mclk);
    serial_activity <= (k == 0);
    radio_activity  <= (k == 1);
    tx_start        <= (k == 2);
    @(posedge mclk);
    serial_activity <= 1'b0;
    radio_activity  <= 1'b0;
    tx_start        <= 1'b0;
    #1;
  endtask : strobe

  task automatic burst(input logic [15:0] n);
    @(posedge mclk);
    burst_go  <= 1'b1;
    burst_len <= n;
    @(posedge mclk);
    burst_go <= 1'b0;
  endtask : burst

  initial begin
    rst_n = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    serial_activity = 1'b0;
    radio_activity = 1'b0;
    tx_pending = 1'b0;
    tx_start = 1'b0;
    burst_go = 1'b0;
    burst_len = 16'h0000;
    pin_level = 1'b1;
    fail_count = 0;
    n_checks = 0;
    void'($urandom(32'h7F86));
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    chk("outputs after reset", 16'h0000, {12'h000, outs});
    rc(sleep_wake_pkg::REG_SLEEP_SELECT, 16'h0000);
    rc(sleep_wake_pkg::REG_INACTIVITY, 16'h0064);
    rc(sleep_wake_pkg::REG_HOLDOFF, 16'hFFFF);
    rc(sleep_wake_pkg::REG_DURATION, 16'h0001);
    rc(sleep_wake_pkg::REG_PIN_WAKE, 16'h0000);
    rc(3'h7, 16'h0000);
    for (int s = 0; s < 9; s++) begin
      wr(sleep_wake_pkg::REG_SLEEP_SELECT, 16'(s));
      rc(sleep_wake_pkg::REG_SLEEP_SELECT, 16'(s == 2 ? 1 : s));
    end
    wr(sleep_wake_pkg::REG_INACTIVITY, 16'h000F);
    rc(sleep_wake_pkg::REG_INACTIVITY, 16'h0010);
    repeat (3) begin
      d = 16'($urandom_range(65535, 16));
      wr(sleep_wake_pkg::REG_INACTIVITY, d);
      rc(sleep_wake_pkg::REG_INACTIVITY, d);
    end
    // Cyclic sleep at the shortest wake period
    wr(sleep_wake_pkg::REG_INACTIVITY, 16'h0010);
    wr(sleep_wake_pkg::REG_SLEEP_SELECT, 16'h0003);
    strobe(1);
    wt("sleep delay", 0, 1'b1, 15 * T, 17 * T + 8);
    wt("wake period", 1, 1'b1, 4 * T, 5 * T + 4);
    burst(16'h0002);
    wt("short initializer", 0, 1'b1, 1, LC + 8);
    wt("second wake", 1, 1'b1, 4 * T, 5 * T + 4);
    burst(16'd30);
    wt("receive start", 2, 1'b1, DC, DC + 10);
    wt("receive end", 2, 1'b0, 16, 40);
    chk("awake after receive", 16'h0000, {12'h000, outs});
    // Pin wake holds the device up
    wr(sleep_wake_pkg::REG_PIN_WAKE, 16'h0001);
    @(posedge mclk);
    pin_level <= 1'b0;
    hold("pin low awake", 0, 1'b0, 20 * T);
    @(posedge mclk);
    pin_level <= 1'b1;
    wt("sleep after pin", 0, 1'b1, 15 * T, 17 * T + 12);
    @(posedge mclk);
    pin_level <= 1'b0;
    wt("pin wakes sleeper", 0, 1'b0, 2, 8);
    @(posedge mclk);
    pin_level <= 1'b1;
    wt("sleep after pin again", 0, 1'b1, 15 * T, 17 * T + 12);
    @(posedge mclk);
    tx_pending <= 1'b1;
    wt("wake on pending", 0, 1'b0, 0, 8);
    hold("pending keeps awake", 0, 1'b0, 18 * T);
    @(posedge mclk);
    tx_pending <= 1'b0;
    // Non-cyclic selections ignore timeout and pin wake
    wr(sleep_wake_pkg::REG_SLEEP_SELECT, 16'h0000);
    hold("disabled never sleeps", 0, 1'b0, 20 * T);
    wr(sleep_wake_pkg::REG_SLEEP_SELECT, 16'h0001);
    wt("pin sleep", 0, 1'b1, 0, 8);
    @(posedge mclk);
    pin_level <= 1'b0;
    wt("pin sleep release", 0, 1'b0, 0, 12);
    wr(sleep_wake_pkg::REG_SLEEP_SELECT, 16'h0000);
    // Forced and holdoff initializers
    // Longer than the 0.5 s interval that the receivers here use
    dur = $urandom_range(8, 6);
    wr(sleep_wake_pkg::REG_DURATION, 16'(dur));
    wr(sleep_wake_pkg::REG_FORCE_INIT, 16'h0000);
    strobe(2);
    chk("forced initializer", 16'h0001, {15'h0, initializer_on});
    wt("initializer length", 3, 1'b0, (dur - 1) * T, dur * T + 2);
    rc(sleep_wake_pkg::REG_STATUS, 16'h0000);
    chk("force cleared", 16'h0000, {15'h0, d[2]});
    repeat (3 * T) @(posedge mclk);
    strobe(2);
    chk("holdoff disabled", 16'h0000, {15'h0, initializer_on});
    wr(sleep_wake_pkg::REG_HOLDOFF, 16'h0003);
    repeat (5 * T) @(posedge mclk);
    strobe(2);
    chk("holdoff initializer", 16'h0001, {15'h0, initializer_on});
    wt("initializer end", 3, 1'b0, 0, dur * T + 2);
    strobe(0);
    strobe(2);
    chk("activity restart", 16'h0000, {15'h0, initializer_on});
    // Slower cyclic selections, picked at random
    wr(sleep_wake_pkg::REG_PIN_WAKE, 16'h0000);
    d = 16'($urandom_range(8, 4));
    w = wake_ticks(int'(d));
    wr(sleep_wake_pkg::REG_SLEEP_SELECT, d);
    wt("sleep slow select", 0, 1'b1, 14 * T, 17 * T);
    wt("slow wake period", 1, 1'b1, (w - 1) * T, w * T + 4);
    test_done();
  end
endmodule : tb
`default_nettype wire
